/* File: logic/loop_clock_pkg.sv */
/*
 * Shared constants for the loop clock control block: register offsets,
 * field positions, reset values and the source switch wait count.
 * Assumes a 32-bit APB slave with one aligned word per register.
 */
package loop_clock_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_BANDWIDTH = 8'h04;
   localparam logic [7:0] OFS_PROGRAMMING = 8'h08;

   // control register fields
   localparam int CTL_IRQ_EN = 7;
   localparam int CTL_EVENT = 6;
   localparam int CTL_POWER = 5;
   localparam int CTL_SELECT = 4;
   localparam logic [3:0] CTL_LOW_ONES = 4'hF;

   // bandwidth register fields
   localparam int BW_AUTO = 7;
   localparam int BW_SETTLED = 6;
   localparam int BW_TRACK = 5;

   // programming register fields
   localparam int PRG_MULT_LSB = 4;
   localparam int PRG_RANGE_LSB = 0;

   // reset values
   localparam logic RST_IRQ_EN = 1'b0;
   localparam logic RST_POWER = 1'b1;
   localparam logic RST_SELECT = 1'b0;
   localparam logic RST_AUTO = 1'b0;
   localparam logic [3:0] RST_MULT = 4'h0;
   localparam logic [3:0] RST_RANGE = 4'h0;

   // multiplier handling
   localparam logic [3:0] MULT_ZERO = 4'h0;
   localparam logic [3:0] MULT_ONE = 4'h1;
   localparam logic [3:0] RANGE_OFF = 4'h0;

   // source clock edges to wait on each side of a switch
   localparam logic [1:0] SWITCH_WAIT = 2'h3;

   // switch states
   typedef enum logic [1:0] {SW_RUN, SW_DRAIN_OLD, SW_FILL_NEW} sw_state_t;
endpackage

/* File: logic/base_clock_switch.sv */
/*
 * Glitch-free selector between the crystal and vco clocks, followed by
 * a divide by two. Both source clocks are sampled as pins on CLOCK,
 * which must run at more than twice the faster source.
 */
`timescale 1ns/1ps
module base_clock_switch
   import loop_clock_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic sel_vco,
   input wire logic crystal_clock,
   input wire logic vco_clock,
   output logic base_clock_out,
   output logic busy
);
   logic [2:0] xs_r;
   logic [2:0] vs_r;
   logic x_rise;
   logic v_rise;
   logic cur_vco_r;
   logic cur_vco_nxt;
   logic [1:0] cnt_r;
   logic [1:0] cnt_nxt;
   logic out_r;
   logic out_nxt;
   sw_state_t state_r;
   sw_state_t state_nxt;
   logic old_rise;
   logic new_rise;

   ////////////////////////////////////////////////////////////////////
   // two-flop synchronisers; stage 0 feeds only stage 1
   always_ff @(posedge clk) begin
      if (rst) begin
         xs_r <= 3'h0;
         vs_r <= 3'h0;
      end else begin
         xs_r <= {xs_r[1:0], crystal_clock};
         vs_r <= {vs_r[1:0], vco_clock};
      end
   end

   // edges are taken from stages 1 and 2 only
   assign x_rise = xs_r[1] & ~xs_r[2];
   assign v_rise = vs_r[1] & ~vs_r[2];
   assign old_rise = cur_vco_r ? v_rise : x_rise;
   assign new_rise = cur_vco_r ? x_rise : v_rise;

   ////////////////////////////////////////////////////////////////////
   // transition control; output is frozen while edges are counted
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      cur_vco_nxt = cur_vco_r;
      out_nxt = out_r;
      case (state_r)
         SW_RUN: begin
            if (sel_vco != cur_vco_r) begin
               state_nxt = SW_DRAIN_OLD;
               cnt_nxt = 2'h0;
            end else if (old_rise) begin
               out_nxt = ~out_r;
            end
         end
         SW_DRAIN_OLD: begin
            if (old_rise) begin
               cnt_nxt = cnt_r + 2'h1;
               if (cnt_r + 2'h1 == SWITCH_WAIT) begin
                  state_nxt = SW_FILL_NEW;
                  cnt_nxt = 2'h0;
               end
            end
         end
         SW_FILL_NEW: begin
            if (new_rise) begin
               cnt_nxt = cnt_r + 2'h1;
               if (cnt_r + 2'h1 == SWITCH_WAIT) begin
                  state_nxt = SW_RUN;
                  cur_vco_nxt = ~cur_vco_r;
                  cnt_nxt = 2'h0;
               end
            end
         end
         default: begin
            state_nxt = SW_RUN;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= SW_RUN;
         cnt_r <= 2'h0;
         cur_vco_r <= 1'b0;
         out_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         cur_vco_r <= cur_vco_nxt;
         out_r <= out_nxt;
      end
   end

   assign base_clock_out = out_r;
   assign busy = (state_r != SW_RUN);

   ////////////////////////////////////////////////////////////////////
   // checks
   a_out_static_switch: assert property (@(posedge clk) disable iff (rst)
      (state_r != SW_RUN) |=> $stable(out_r))
      else $error("base clock moved during a source switch");
   a_out_div_two: assert property (@(posedge clk) disable iff (rst)
      (state_r == SW_RUN && sel_vco == cur_vco_r && old_rise)
      |=> out_r != $past(out_r))
      else $error("base clock missed a source edge");
   c_switch_done: cover property (@(posedge clk) disable iff (rst)
      state_r == SW_FILL_NEW ##1 state_r == SW_RUN);
endmodule // base_clock_switch

/* File: logic/loop_clock_control.sv */
/*
 * Loop bandwidth control, settle indication, multiplier fields and
 * base clock selection with power/select interlocks, behind APB.
 * Assumes tolerance comparator levels arrive asynchronously from the
 * analog loop, and the stop request is a pulse on CLOCK.
 */
// Functional notes
// - in automatic mode the detector moves filter between acquire and track
// - auto mode: track bit read-only, sets in track, clears out of untrack
// - auto mode: settled flag read-only, sets in lock, clears when unlocked
// - auto mode with event enable, each settled toggle raises interrupt
// - manual mode: track bit writable, 0 acquire, 1 track
// - manual mode hides settled indication and suppresses interrupts
// - upper nibble of programming register is feedback multiplier
// - lower nibble of programming register is range multiplier
// - feedback multiplier zero behaves as one
// - range zero disables loop and forces crystal source
// - source switch waits three edges of each clock, output held
// - switch output divided by two forms base clock
// - selecting vco ignored while loop power is off
// - clearing loop power ignored while vco is selected
// - one write cannot change both power and vco selection
// - event flag sets on settled toggle, control read clears it
// - manual mode: event flag and settled flag read zero
// - reset and stop clear source select back to crystal
// - reset sets loop power, but range resets to zero so loop stays disabled at power up
`timescale 1ns/1ps
module loop_clock_control
   import loop_clock_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic CRYSTAL_CLOCK,
   input wire logic VCO_CLOCK,
   input wire logic IN_TRACK_TOL,
   input wire logic OUT_UNTRACK_TOL,
   input wire logic IN_LOCK_TOL,
   input wire logic OUT_UNLOCK_TOL,
   input wire logic STOP_REQ,
   output logic LOOP_ENABLE,
   output logic FILTER_TRACK,
   output logic [3:0] FEEDBACK_MULT,
   output logic [3:0] RANGE_MULT,
   output logic BASE_CLOCK_OUT,
   output logic SWITCH_BUSY,
   output logic CLOCK_UNIT_IRQ
);
   logic [3:0] tol_m_r;
   logic [3:0] tol_s_r;
   logic in_trk;
   logic out_unt;
   logic in_lck;
   logic out_unl;
   logic irq_en_r;
   logic irq_en_nxt;
   logic event_r;
   logic event_nxt;
   logic power_r;
   logic power_nxt;
   logic select_r;
   logic select_nxt;
   logic auto_r;
   logic auto_nxt;
   logic track_r;
   logic track_nxt;
   logic settled_r;
   logic settled_nxt;
   logic [3:0] mult_r;
   logic [3:0] mult_nxt;
   logic [3:0] range_r;
   logic [3:0] range_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic setup;
   logic access;
   logic wr;
   logic rd_ctl;
   logic hit;
   logic [7:0] ctl_rd;
   logic [7:0] bw_rd;
   logic w_power;
   logic w_select;

   ////////////////////////////////////////////////////////////////////
   // tolerance levels come from the analog side: two flops each
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         tol_m_r <= 4'h0;
         tol_s_r <= 4'h0;
      end else begin
         tol_m_r <= {IN_TRACK_TOL, OUT_UNTRACK_TOL, IN_LOCK_TOL,
                     OUT_UNLOCK_TOL};
         tol_s_r <= tol_m_r;
      end
   end

   assign in_trk = tol_s_r[3];
   assign out_unt = tol_s_r[2];
   assign in_lck = tol_s_r[1];
   assign out_unl = tol_s_r[0];

   ////////////////////////////////////////////////////////////////////
   // apb decode; zero wait states, pready always high
   assign setup = PSEL & ~PENABLE;
   assign access = PSEL & PENABLE;
   assign wr = access & PWRITE;
   assign hit = (PADDR == OFS_CONTROL) || (PADDR == OFS_BANDWIDTH) ||
                (PADDR == OFS_PROGRAMMING);
   // clear only an event that the reader actually saw, so an event that
   // lands between setup and access is kept for the next read
   assign rd_ctl = access & ~PWRITE & (PADDR == OFS_CONTROL) &
                   rdata_r[CTL_EVENT];
   assign w_power = PWDATA[CTL_POWER];
   assign w_select = PWDATA[CTL_SELECT];

   // read views; enable and flags read zero in manual mode
   always_comb begin
      ctl_rd = {irq_en_r & auto_r, event_r & auto_r, power_r, select_r,
                CTL_LOW_ONES};
      bw_rd = 8'h00;
      bw_rd[BW_AUTO] = auto_r;
      bw_rd[BW_SETTLED] = settled_r & auto_r;
      bw_rd[BW_TRACK] = track_r;
   end

   ////////////////////////////////////////////////////////////////////
   // control, bandwidth mode and programming register next state
   always_comb begin
      irq_en_nxt = irq_en_r;
      power_nxt = power_r;
      select_nxt = select_r;
      auto_nxt = auto_r;
      mult_nxt = mult_r;
      range_nxt = range_r;
      if (wr && PADDR == OFS_CONTROL) begin
         if (auto_r) begin
            irq_en_nxt = PWDATA[CTL_IRQ_EN];
         end
         if (!select_r) begin
            power_nxt = w_power;
         end
         if (w_power == power_r && power_r) begin
            select_nxt = w_select;
         end else if (w_power == power_r && !w_select) begin
            select_nxt = 1'b0;
         end
      end
      if (wr && PADDR == OFS_BANDWIDTH) begin
         auto_nxt = PWDATA[BW_AUTO];
      end
      // programming word is frozen while the loop is powered
      if (wr && PADDR == OFS_PROGRAMMING && !power_r) begin
         mult_nxt = PWDATA[PRG_MULT_LSB +: 4];
         range_nxt = PWDATA[PRG_RANGE_LSB +: 4];
      end
      if (range_r == RANGE_OFF || STOP_REQ) begin
         select_nxt = 1'b0;
      end
      if (!auto_nxt) begin
         irq_en_nxt = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // filter mode, settle indication and event flag
   always_comb begin
      track_nxt = track_r;
      settled_nxt = settled_r;
      event_nxt = event_r;
      if (auto_r) begin
         if (in_trk) begin
            track_nxt = 1'b1;
         end else if (out_unt) begin
            track_nxt = 1'b0;
         end
         if (in_lck) begin
            settled_nxt = 1'b1;
         end else if (out_unl) begin
            settled_nxt = 1'b0;
         end
      end else begin
         settled_nxt = 1'b0;
         if (wr && PADDR == OFS_BANDWIDTH) begin
            track_nxt = PWDATA[BW_TRACK];
         end
      end
      // set wins over a clearing read in the same cycle
      if (!auto_r) begin
         event_nxt = 1'b0;
      end else if (settled_nxt != settled_r) begin
         event_nxt = 1'b1;
      end else if (rd_ctl) begin
         event_nxt = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read data captured in setup so it is stable for the access phase
   always_comb begin
      rdata_nxt = rdata_r;
      if (setup && !PWRITE) begin
         rdata_nxt = 32'h0000_0000;
         case (PADDR)
            OFS_CONTROL: rdata_nxt[7:0] = ctl_rd;
            OFS_BANDWIDTH: rdata_nxt[7:0] = bw_rd;
            OFS_PROGRAMMING: rdata_nxt[7:0] = {mult_r, range_r};
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // state registers
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         irq_en_r <= RST_IRQ_EN;
         event_r <= 1'b0;
         power_r <= RST_POWER;
         select_r <= RST_SELECT;
         auto_r <= RST_AUTO;
         track_r <= 1'b0;
         settled_r <= 1'b0;
         mult_r <= RST_MULT;
         range_r <= RST_RANGE;
         rdata_r <= 32'h0000_0000;
      end else begin
         irq_en_r <= irq_en_nxt;
         event_r <= event_nxt;
         power_r <= power_nxt;
         select_r <= select_nxt;
         auto_r <= auto_nxt;
         track_r <= track_nxt;
         settled_r <= settled_nxt;
         mult_r <= mult_nxt;
         range_r <= range_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs
   assign PRDATA = rdata_r;
   assign PREADY = 1'b1;
   assign PSLVERR = access & ~hit;
   assign LOOP_ENABLE = power_r & (range_r != RANGE_OFF);
   assign FILTER_TRACK = track_r;
   assign FEEDBACK_MULT = (mult_r == MULT_ZERO) ? MULT_ONE : mult_r;
   assign RANGE_MULT = range_r;
   assign CLOCK_UNIT_IRQ = auto_r & irq_en_r & event_r;

   // the switch only ever sees a select the interlocks have allowed
   base_clock_switch i_base_clock_switch (
      .clk(CLOCK),
      .rst(RESET),
      .sel_vco(select_r),
      .crystal_clock(CRYSTAL_CLOCK),
      .vco_clock(VCO_CLOCK),
      .base_clock_out(BASE_CLOCK_OUT),
      .busy(SWITCH_BUSY)
   );

   ////////////////////////////////////////////////////////////////////
   // checks
   a_select_needs_power: assert property (@(posedge CLOCK)
      disable iff (RESET) select_r |-> power_r)
      else $error("vco selected with loop off");
   a_power_held_sel: assert property (@(posedge CLOCK) disable iff (RESET)
      (select_r && wr && PADDR == OFS_CONTROL && !w_power) |=> power_r)
      else $error("loop power cleared while vco selected");
   a_one_change_write: assert property (@(posedge CLOCK)
      disable iff (RESET)
      ##1 !($changed(power_r) && $changed(select_r)))
      else $error("power and select changed together");
   a_range_zero_xtal: assert property (@(posedge CLOCK)
      disable iff (RESET) (range_r == RANGE_OFF) |=> !select_r)
      else $error("vco selected with range zero");
   a_mult_zero_one: assert property (@(posedge CLOCK) disable iff (RESET)
      (mult_r == MULT_ZERO) |-> (FEEDBACK_MULT == MULT_ONE))
      else $error("zero multiplier not taken as one");
   a_manual_quiet: assert property (@(posedge CLOCK) disable iff (RESET)
      !auto_r |=> !CLOCK_UNIT_IRQ && !bw_rd[BW_SETTLED])
      else $error("manual mode shows settle or interrupt");
   a_toggle_sets_event: assert property (@(posedge CLOCK)
      disable iff (RESET)
      ($past(auto_r) && $changed(settled_r)) |-> event_r)
      else $error("settled toggle did not set event");
   // follows a settle toggle through the event flag to the request line
   a_event_irq: assert property (@(posedge CLOCK) disable iff (RESET)
      ($past(auto_r) && auto_r && irq_en_r && $changed(settled_r))
      |-> CLOCK_UNIT_IRQ)
      else $error("enabled event gave no interrupt");
   a_stop_clears_sel: assert property (@(posedge CLOCK)
      disable iff (RESET) STOP_REQ |=> !select_r)
      else $error("stop left vco selected");
   a_track_auto_set: assert property (@(posedge CLOCK)
      disable iff (RESET) (auto_r && in_trk) |=> track_r)
      else $error("track bit not set inside tolerance");
   c_vco_selected: cover property (@(posedge CLOCK) disable iff (RESET)
      !select_r ##1 select_r);
   c_irq_raised: cover property (@(posedge CLOCK) disable iff (RESET)
      !CLOCK_UNIT_IRQ ##1 CLOCK_UNIT_IRQ);
   c_event_read: cover property (@(posedge CLOCK) disable iff (RESET)
      rd_ctl ##1 !event_r);
endmodule // loop_clock_control

/* File: tb/base_clock_consumer.sv */
/*
 * Consumer of the base clock: measures phase lengths in CLOCK cycles
 * and issues the stop request pulse when the bench commands it.
 * Assumes the base clock is sampled as a level on clk.
 */
`timescale 1ns/1ps
module base_clock_consumer (
   input wire logic clk,
   input wire logic rst,
   input wire logic base_clock_out,
   input wire logic stop_cmd,
   input wire logic meas_clr,
   output logic stop_req,
   output logic [7:0] last_phase,
   output logic [7:0] min_phase
);
   logic stop_r = 1'b0;
   logic prev_r = 1'b0;
   logic seen_r = 1'b0;
   logic [7:0] run_r = 8'h00;

   assign stop_req = stop_r;

   ////////////////////////////////////////////////////////////////////
   // phase meter: the first phase after a clear is partial, so skipped
   always @(posedge clk) begin
      stop_r <= stop_cmd & ~rst;
      prev_r <= base_clock_out;
      if (rst || meas_clr) begin
         run_r <= 8'h00;
         seen_r <= 1'b0;
         min_phase <= 8'hFF;
         last_phase <= 8'h00;
      end else if (base_clock_out != prev_r) begin
         run_r <= 8'h00;
         seen_r <= 1'b1;
         last_phase <= run_r + 8'h01;
         if (seen_r && run_r + 8'h01 < min_phase) begin
            min_phase <= run_r + 8'h01;
         end
      end else if (run_r != 8'hFF) begin
         run_r <= run_r + 8'h01;
      end
   end
endmodule // base_clock_consumer

/* File: tb/loop_clock_control_tb_top.sv */
/*
 * Self-checking bench for the loop clock control block over APB.
 * Assumes zero-wait APB and source clocks no faster than CLOCK/8.
 */
`timescale 1ns/1ps
module loop_clock_control_tb_top;
   import loop_clock_pkg::*;
   logic CLOCK = 1'b0;
   logic RESET = 1'b1;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0;
   logic [31:0] PRDATA;
   logic PREADY, PSLVERR, STOP_REQ, LOOP_ENABLE, FILTER_TRACK;
   logic CRYSTAL_CLOCK = 1'b0;
   logic VCO_CLOCK = 1'b0;
   logic IN_TRACK_TOL = 1'b0;
   logic OUT_UNTRACK_TOL = 1'b0;
   logic IN_LOCK_TOL = 1'b0;
   logic OUT_UNLOCK_TOL = 1'b0;
   logic BASE_CLOCK_OUT, SWITCH_BUSY, CLOCK_UNIT_IRQ;
   logic [3:0] FEEDBACK_MULT, RANGE_MULT;
   logic stop_cmd = 1'b0;
   logic meas_clr = 1'b0;
   logic [7:0] last_phase, min_phase;
   int fail_count = 0;
   int total_checks = 0;
   int xc_n = 0;
   int vc_n = 3;

   initial begin
      forever #25 CLOCK = ~CLOCK;
   end

   // sources: crystal 8 cycles, vco 10 cycles, unrelated phases
   always @(posedge CLOCK) begin
      xc_n <= (xc_n + 1) % 8;
      vc_n <= (vc_n + 1) % 10;
      CRYSTAL_CLOCK <= (xc_n < 4);
      VCO_CLOCK <= (vc_n < 5);
   end

   loop_clock_control i_loop_clock_control (.CLOCK(CLOCK), .RESET(RESET),
      .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
      .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .CRYSTAL_CLOCK(CRYSTAL_CLOCK),
      .VCO_CLOCK(VCO_CLOCK), .IN_TRACK_TOL(IN_TRACK_TOL),
      .OUT_UNTRACK_TOL(OUT_UNTRACK_TOL), .IN_LOCK_TOL(IN_LOCK_TOL),
      .OUT_UNLOCK_TOL(OUT_UNLOCK_TOL), .STOP_REQ(STOP_REQ),
      .LOOP_ENABLE(LOOP_ENABLE), .FILTER_TRACK(FILTER_TRACK),
      .FEEDBACK_MULT(FEEDBACK_MULT), .RANGE_MULT(RANGE_MULT),
      .BASE_CLOCK_OUT(BASE_CLOCK_OUT), .SWITCH_BUSY(SWITCH_BUSY),
      .CLOCK_UNIT_IRQ(CLOCK_UNIT_IRQ));

   base_clock_consumer i_base_clock_consumer (.clk(CLOCK), .rst(RESET),
      .base_clock_out(BASE_CLOCK_OUT), .stop_cmd(stop_cmd),
      .meas_clr(meas_clr), .stop_req(STOP_REQ),
      .last_phase(last_phase), .min_phase(min_phase));

   /////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge CLOCK);
   endtask

   // one APB transfer; holds the request until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      int n;
      n = 0;
      @(posedge CLOCK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= wd;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      do begin
         @(posedge CLOCK);
         n++;
      end while (PREADY !== 1'b1 && n < 40);
      chk("pready", 32'h1, {31'h0, PREADY});
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   // write, then let the write edge land before returning
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, {24'h0, d}, r, e);
      @(posedge CLOCK);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                     input string what);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(what, {24'h0, exp}, r);
   endtask

   /////////////////////////////////////////////////////////////////////
   task automatic t_reset_vals;
      logic [31:0] r;
      logic e;
      rd(OFS_CONTROL, 8'h2F, "control");
      rd(OFS_BANDWIDTH, 8'h00, "bandwidth");
      rd(OFS_PROGRAMMING, 8'h00, "programming");
      apb(1'b0, 8'h0C, 32'h0, r, e);
      chk("unmapped data", 32'h0, r);
      chk("unmapped error", 32'h1, {31'h0, e});
      chk("mult zero", 32'h1, {28'h0, FEEDBACK_MULT});
      wr(OFS_CONTROL, 8'h30);
      rd(OFS_CONTROL, 8'h2F, "select range zero");
      chk("loop enable", 32'h0, {31'h0, LOOP_ENABLE});
   endtask

   // power/select interlocks and programming lock, with the loop powered down and up
   task automatic t_interlock;
      wr(OFS_CONTROL, 8'h00);
      wr(OFS_PROGRAMMING, 8'h07);
      rd(OFS_PROGRAMMING, 8'h07, "programming");
      chk("mult zero as one", 32'h1, {28'h0, FEEDBACK_MULT});
      chk("range mult", 32'h7, {28'h0, RANGE_MULT});
      wr(OFS_PROGRAMMING, 8'h87);
      chk("feedback mult", 32'h8, {28'h0, FEEDBACK_MULT});
      wr(OFS_CONTROL, 8'h10);
      rd(OFS_CONTROL, 8'h0F, "select while off");
      wr(OFS_CONTROL, 8'h30);
      rd(OFS_CONTROL, 8'h2F, "power and select");
      chk("loop enable on", 32'h1, {31'h0, LOOP_ENABLE});
      wr(OFS_PROGRAMMING, 8'h55);
      rd(OFS_PROGRAMMING, 8'h87, "programming locked");
   endtask

   // switch by write or stop; output must freeze, then run at new rate
   task automatic switch_to(input logic by_stop, input logic [7:0] ctl,
                            input logic [7:0] half, input string what);
      logic held;
      int n;
      int moved;
      moved = 0;
      meas_clr <= 1'b1;
      if (by_stop) begin
         stop_cmd <= 1'b1;
         cyc(1);
         stop_cmd <= 1'b0;
      end else begin
         wr(OFS_CONTROL, ctl);
      end
      meas_clr <= 1'b0;
      n = 0;
      while (SWITCH_BUSY !== 1'b1 && n < 10) begin
         @(posedge CLOCK);
         n++;
      end
      chk({what, " busy"}, 32'h1, {31'h0, SWITCH_BUSY});
      held = BASE_CLOCK_OUT;
      n = 0;
      while (SWITCH_BUSY === 1'b1 && n < 90) begin
         if (BASE_CLOCK_OUT !== held) moved++;
         @(posedge CLOCK);
         n++;
      end
      chk({what, " frozen"}, 32'h0, moved);
      chk({what, " ends"}, 32'h1, {31'h0, n < 90});
      cyc(60);
      chk({what, " half period"}, {24'h0, half}, {24'h0, last_phase});
      chk({what, " no runt"}, 32'h1, {31'h0, min_phase >= 8'h08});
   endtask

   task automatic t_switch;
      wr(OFS_BANDWIDTH, 8'h20);
      cyc(20);
      switch_to(1'b0, 8'h30, 8'h0A, "to vco");
      rd(OFS_CONTROL, 8'h3F, "vco selected");
      wr(OFS_CONTROL, 8'h00);
      rd(OFS_CONTROL, 8'h3F, "power held");
      switch_to(1'b1, 8'h00, 8'h08, "stop");
      rd(OFS_CONTROL, 8'h2F, "after stop");
   endtask

   task automatic t_auto;
      wr(OFS_BANDWIDTH, 8'h80);
      wr(OFS_CONTROL, 8'hA0);
      IN_LOCK_TOL <= 1'b1;
      IN_TRACK_TOL <= 1'b1;
      cyc(6);
      chk("irq on lock", 32'h1, {31'h0, CLOCK_UNIT_IRQ});
      chk("auto track", 32'h1, {31'h0, FILTER_TRACK});
      rd(OFS_BANDWIDTH, 8'hE0, "locked");
      wr(OFS_CONTROL, 8'hB0);
      // track input released so a leaking write would not be re-set
      IN_TRACK_TOL <= 1'b0;
      wr(OFS_BANDWIDTH, 8'h80);
      rd(OFS_BANDWIDTH, 8'hE0, "track read only");
      rd(OFS_CONTROL, 8'hFF, "event set");
      cyc(1);
      chk("irq cleared", 32'h0, {31'h0, CLOCK_UNIT_IRQ});
      rd(OFS_CONTROL, 8'hBF, "event cleared");
      IN_LOCK_TOL <= 1'b0;
      IN_TRACK_TOL <= 1'b0;
      OUT_UNLOCK_TOL <= 1'b1;
      OUT_UNTRACK_TOL <= 1'b1;
      cyc(6);
      chk("irq on unlock", 32'h1, {31'h0, CLOCK_UNIT_IRQ});
      rd(OFS_BANDWIDTH, 8'h80, "unlocked");
      // recovery from a noise hit: fall back to the crystal source
      wr(OFS_CONTROL, 8'hA0);
      rd(OFS_CONTROL, 8'hEF, "back to crystal");
      OUT_UNLOCK_TOL <= 1'b0;
      OUT_UNTRACK_TOL <= 1'b0;
      IN_LOCK_TOL <= 1'b1;
      cyc(6);
   endtask

   // lock stays asserted here, so hiding it is really exercised
   task automatic t_manual;
      wr(OFS_BANDWIDTH, 8'h00);
      rd(OFS_BANDWIDTH, 8'h00, "manual flags");
      chk("manual irq", 32'h0, {31'h0, CLOCK_UNIT_IRQ});
      rd(OFS_CONTROL, 8'h2F, "manual control");
      wr(OFS_BANDWIDTH, 8'h20);
      chk("manual track", 32'h1, {31'h0, FILTER_TRACK});
      rd(OFS_BANDWIDTH, 8'h20, "manual track read");
      wr(OFS_BANDWIDTH, 8'h00);
      chk("manual acquire", 32'h0, {31'h0, FILTER_TRACK});
   endtask

   task automatic t_reset_again;
      wr(OFS_CONTROL, 8'h30);
      RESET <= 1'b1;
      cyc(2);
      RESET <= 1'b0;
      rd(OFS_CONTROL, 8'h2F, "second reset");
      rd(OFS_PROGRAMMING, 8'h00, "programming reset");
   endtask

   /////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      cyc(2);
      RESET <= 1'b0;
      t_reset_vals;
      t_interlock;
      t_switch;
      t_auto;
      t_manual;
      t_reset_again;
      close_out;
   end

   // the run needs about 400 cycles; far beyond that means a hang
   initial begin
      #(50 * 20000);
      fail_count++;
      close_out;
   end
endmodule // loop_clock_control_tb_top
